// ---- timer_counter.sv ----
// 16-bit timer counter with prescaler, overflow flag and input-capture channels
`timescale 1ns/10ps
module timer_counter
    import timer_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire bus_req_t bus,
    output logic [7:0] rdata,
    // clock sources and debug
    input wire logic ext_clk_pin,
    input wire logic fixed_clk_tick,
    input wire logic debug_mode,
    // channel pins and requests
    input wire logic [NUM_CH-1:0] channel_pin,
    output logic [NUM_CH-1:0] channel_irq,
    output logic overflow_irq
);
    state_t q;
    state_t next_q;
    logic cnt_wr;
    logic src_tick;
    logic cnt_tick;
    logic free_run;
    logic [7:0] div_shift;
    logic [6:0] pre_mask;
    logic [NUM_CH-1:0] ic_mode;
    logic [NUM_CH-1:0] cap_event;
    logic [3:0] addr_ctl [NUM_CH];
    logic [3:0] addr_vh [NUM_CH];
    logic [3:0] addr_vl [NUM_CH];

    // counter clock selection; external clock edge only after the synchroniser
    assign cnt_wr = bus.wr && (bus.addr == ADDR_COUNTER_HIGH || bus.addr == ADDR_COUNTER_LOW);
    always_comb begin
        case (q.clock_source_select)
            CLK_SYSTEM: src_tick = 1'b1;
            CLK_FIXED: src_tick = fixed_clk_tick;
            CLK_EXTERNAL: src_tick = q.ext_sync[1] & ~q.ext_sync[2];
            default: src_tick = 1'b0;
        endcase
    end

    // prescaler: count wraps at 2^presc-1, giving divide by 1..128
    assign div_shift = 8'h01 << q.presc;
    assign pre_mask = 7'(div_shift - 8'h01);
    assign cnt_tick = src_tick && ((q.pre_cnt & pre_mask) == pre_mask) && !debug_mode;
    assign free_run = (q.modulo == COUNT_ZERO) || (q.modulo == COUNT_ALL_ONES);

    // per-channel decode, edge detect and request lines
    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : gch
        logic rise;
        logic fall;
        assign addr_ctl[g] = ADDR_CH_CONTROL_BASE + 4'(g) * ADDR_CH_STRIDE;
        assign addr_vh[g] = ADDR_CH_VALUE_HIGH_BASE + 4'(g) * ADDR_CH_STRIDE;
        assign addr_vl[g] = ADDR_CH_VALUE_LOW_BASE + 4'(g) * ADDR_CH_STRIDE;
        assign ic_mode[g] = !q.center && q.ch[g].mode == MODE_CAPTURE
                            && q.ch[g].edge_sel != 2'h0;
        assign rise = q.ch[g].pin_sync[1] & ~q.ch[g].pin_sync[2];
        assign fall = ~q.ch[g].pin_sync[1] & q.ch[g].pin_sync[2];
        assign cap_event[g] = ic_mode[g] && ((q.ch[g].edge_sel[0] && rise)
                              || (q.ch[g].edge_sel[1] && fall));
        assign channel_irq[g] = q.ch[g].flag && q.ch[g].irq_en;
    end
    assign overflow_irq = q.overflow && q.overflow_irq_en;
    assign rdata = q.rdata;

    // whole next state of the block
    always_comb begin
        logic tof_set;
        logic is_hi;
        logic oc_mode;
        logic upd_now;
        tof_set = 1'b0;
        is_hi = 1'b0;
        oc_mode = 1'b0;
        upd_now = 1'b0;
        next_q = q;
        next_q.rdata = 8'h00;
        // synchronisers: first stage feeds only the second
        next_q.ext_sync = {q.ext_sync[1:0], ext_clk_pin};
        for (int i = 0; i < NUM_CH; i++) begin
            next_q.ch[i].pin_sync = {q.ch[i].pin_sync[1:0], channel_pin[i]};
        end

        // counter; a byte write wins over counting, even in debug
        if (cnt_wr) begin
            next_q.count = COUNT_ZERO;
            next_q.pre_cnt = 7'h00;
            next_q.count_down = 1'b0;
        end else if (src_tick && !debug_mode) begin
            next_q.pre_cnt = cnt_tick ? 7'h00 : q.pre_cnt + 7'h01;
            if (cnt_tick) begin
                if (free_run) begin
                    next_q.count = q.count + 16'h0001;
                    tof_set = (q.count == COUNT_ALL_ONES);
                end else if (!q.center) begin
                    if (q.count >= q.modulo) begin
                        next_q.count = COUNT_ZERO;
                        tof_set = 1'b1;
                    end else begin
                        next_q.count = q.count + 16'h0001;
                    end
                end else if (!q.count_down) begin
                    if (q.count >= q.modulo) begin
                        next_q.count = q.modulo - 16'h0001;
                        next_q.count_down = 1'b1;
                        tof_set = 1'b1;
                    end else begin
                        next_q.count = q.count + 16'h0001;
                    end
                end else if (q.count == COUNT_ZERO) begin
                    next_q.count = 16'h0001;
                    next_q.count_down = 1'b0;
                end else begin
                    next_q.count = q.count - 16'h0001;
                end
            end
        end

        // register reads; data stand in the following cycle only
        if (bus.rd) begin
            case (bus.addr)
                ADDR_STATUS_CONTROL: begin
                    next_q.rdata = {q.overflow, q.overflow_irq_en, q.center, q.clock_source_select, q.presc};
                    next_q.overflow_armed = q.overflow;
                end
                ADDR_COUNTER_HIGH: next_q.rdata = q.count[15:8];
                ADDR_COUNTER_LOW: next_q.rdata = q.count[7:0];
                ADDR_MODULO_HIGH: next_q.rdata = q.modulo[15:8];
                ADDR_MODULO_LOW: next_q.rdata = q.modulo[7:0];
                default: next_q.rdata = 8'h00;
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                if (bus.addr == addr_ctl[i]) begin
                    next_q.rdata = {q.ch[i].flag, q.ch[i].irq_en, q.ch[i].mode,
                                    q.ch[i].edge_sel, 2'b00};
                    next_q.ch[i].clear_armed = q.ch[i].flag;
                end
                if (bus.addr == addr_vh[i] || bus.addr == addr_vl[i]) begin
                    is_hi = (bus.addr == addr_vh[i]);
                    if (debug_mode || !ic_mode[i]) begin
                        // debug bypasses the latch and leaves it as it was
                        next_q.rdata = is_hi ? q.ch[i].value[15:8] : q.ch[i].value[7:0];
                    end else if (q.ch[i].rd_latched) begin
                        next_q.rdata = is_hi ? q.ch[i].rd_buf[15:8] : q.ch[i].rd_buf[7:0];
                        if (is_hi != q.ch[i].rd_first_high) begin
                            next_q.ch[i].rd_latched = 1'b0;
                        end
                    end else begin
                        // freeze the pair so a capture between byte reads cannot tear it
                        next_q.rdata = is_hi ? q.ch[i].value[15:8] : q.ch[i].value[7:0];
                        next_q.ch[i].rd_buf = q.ch[i].value;
                        next_q.ch[i].rd_latched = 1'b1;
                        next_q.ch[i].rd_first_high = is_hi;
                    end
                end
            end
        end

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                ADDR_STATUS_CONTROL: begin
                    next_q.overflow_irq_en = bus.wdata[BIT_IRQ_EN];
                    next_q.center = bus.wdata[BIT_CENTER];
                    next_q.clock_source_select = bus.wdata[4:3];
                    next_q.presc = bus.wdata[2:0];
                    if (!bus.wdata[BIT_FLAG] && q.overflow_armed) begin
                        next_q.overflow = 1'b0;
                    end
                    next_q.overflow_armed = 1'b0;
                    next_q.mod_high_seen = 1'b0;
                    next_q.mod_low_seen = 1'b0;
                end
                ADDR_MODULO_HIGH: begin
                    if (debug_mode) begin
                        next_q.modulo[15:8] = bus.wdata;
                    end else begin
                        next_q.mod_buf[15:8] = bus.wdata;
                        next_q.mod_high_seen = 1'b1;
                    end
                end
                ADDR_MODULO_LOW: begin
                    if (debug_mode) begin
                        next_q.modulo[7:0] = bus.wdata;
                    end else begin
                        next_q.mod_buf[7:0] = bus.wdata;
                        next_q.mod_low_seen = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                if (bus.addr == addr_ctl[i]) begin
                    next_q.ch[i].irq_en = bus.wdata[BIT_IRQ_EN];
                    next_q.ch[i].mode = bus.wdata[5:4];
                    next_q.ch[i].edge_sel = bus.wdata[3:2];
                    // writing one has no effect; zero clears only after an armed read
                    if (!bus.wdata[BIT_FLAG] && q.ch[i].clear_armed) begin
                        next_q.ch[i].flag = 1'b0;
                    end
                    next_q.ch[i].clear_armed = 1'b0;
                    next_q.ch[i].rd_latched = 1'b0;
                    next_q.ch[i].wr_high_seen = 1'b0;
                    next_q.ch[i].wr_low_seen = 1'b0;
                end
                if (bus.addr == addr_vh[i] || bus.addr == addr_vl[i]) begin
                    is_hi = (bus.addr == addr_vh[i]);
                    if (ic_mode[i]) begin
                        next_q.ch[i].value = q.ch[i].value;
                    end else if (debug_mode) begin
                        // direct write; sequencing state stays frozen
                        if (is_hi) begin
                            next_q.ch[i].value[15:8] = bus.wdata;
                        end else begin
                            next_q.ch[i].value[7:0] = bus.wdata;
                        end
                    end else if (is_hi) begin
                        next_q.ch[i].wr_buf[15:8] = bus.wdata;
                        next_q.ch[i].wr_high_seen = 1'b1;
                    end else begin
                        next_q.ch[i].wr_buf[7:0] = bus.wdata;
                        next_q.ch[i].wr_low_seen = 1'b1;
                    end
                end
            end
        end

        // buffered modulo takes effect when stopped, else at the overflow point
        if (next_q.mod_high_seen && next_q.mod_low_seen && !debug_mode
            && (q.clock_source_select == CLK_NONE || tof_set)) begin
            next_q.modulo = next_q.mod_buf;
            next_q.mod_high_seen = 1'b0;
            next_q.mod_low_seen = 1'b0;
        end

        // overflow flag: a set in the clearing cycle wins
        if (tof_set) begin
            next_q.overflow = 1'b1;
            next_q.overflow_armed = 1'b0;
        end

        // channel buffer transfer and capture events
        for (int i = 0; i < NUM_CH; i++) begin
            oc_mode = !q.center && q.ch[i].mode == MODE_COMPARE;
            upd_now = (q.clock_source_select == CLK_NONE) || (oc_mode ? cnt_tick : tof_set);
            if (next_q.ch[i].wr_high_seen && next_q.ch[i].wr_low_seen && !debug_mode
                && upd_now) begin
                next_q.ch[i].value = next_q.ch[i].wr_buf;
                next_q.ch[i].wr_high_seen = 1'b0;
                next_q.ch[i].wr_low_seen = 1'b0;
            end
            if (cap_event[i]) begin
                next_q.ch[i].value = q.count;
                next_q.ch[i].flag = 1'b1;
                next_q.ch[i].clear_armed = 1'b0;
            end
        end
    end

    // state register; clock source resets to none
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= STATE_RESET;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_stop_holds: assert property ((q.clock_source_select == CLK_NONE && !cnt_wr) |=> $stable(q.count))
        else $error("counter moved with no clock source");
    a_counter_clear: assert property (cnt_wr |=> (q.count == 16'h0000 && q.pre_cnt == 7'h00))
        else $error("counter write did not clear counter");
    a_debug_freeze: assert property ((debug_mode && !cnt_wr) |=> $stable(q.count))
        else $error("counter moved in debug");
    a_up_wrap: assert property ((cnt_tick && !cnt_wr && !q.center && !free_run
        && q.count == q.modulo) |=> (q.count == 16'h0000 && q.overflow))
        else $error("up count wrap wrong");
    a_free_wrap: assert property ((cnt_tick && !cnt_wr && free_run
        && q.count == 16'hffff) |=> (q.count == 16'h0000 && q.overflow))
        else $error("free run wrap wrong");
    a_updown_turn: assert property ((cnt_tick && !cnt_wr && q.center && !free_run
        && !q.count_down && q.count == q.modulo)
        |=> (q.count == $past(q.modulo) - 16'h0001 && q.overflow && q.count_down))
        else $error("up-down turn wrong");
    a_capture_value: assert property (cap_event[0]
        |=> (q.ch[0].value == $past(q.count) && q.ch[0].flag))
        else $error("capture value or flag wrong");
    a_pin_latency: assert property (($past(reset_n) && $past(reset_n, 2))
        |-> q.ch[0].pin_sync[1] == $past(channel_pin[0], 2))
        else $error("capture synchroniser depth wrong");
    a_ic_write_block: assert property ((bus.wr && bus.addr == addr_vl[0] && ic_mode[0]
        && !cap_event[0]) |=> $stable(q.ch[0].value))
        else $error("capture value changed by write");
    a_latch_release: assert property ((bus.wr && bus.addr == addr_ctl[0])
        |=> !q.ch[0].rd_latched)
        else $error("control write kept read latch");
    a_debug_read: assert property ((bus.rd && debug_mode && bus.addr == addr_vh[0])
        |=> rdata == $past(q.ch[0].value[15:8]))
        else $error("debug read not direct");
    a_debug_latch: assert property ((debug_mode && !(bus.wr && bus.addr == addr_ctl[0]))
        |=> $stable(q.ch[0].rd_latched))
        else $error("read latch changed in debug");
    a_one_ignored: assert property ((bus.wr && bus.addr == addr_ctl[0]
        && bus.wdata[BIT_FLAG] && q.ch[0].flag) |=> q.ch[0].flag)
        else $error("writing one cleared flag");
    // reset itself is what this one watches, so the default disable must not apply
    a_reset_stop: assert property (disable iff (1'b0) !reset_n
        |=> (q.clock_source_select == CLK_NONE && q.count == 16'h0000))
        else $error("reset left a clock source");
    a_up_step: assert property ((cnt_tick && !cnt_wr && !q.center && !free_run
        && q.count < q.modulo) |=> q.count == $past(q.count) + 16'h0001)
        else $error("up count step wrong");
    a_fall_edge: assert property ((ic_mode[1] && q.ch[1].edge_sel[1]
        && !q.ch[1].pin_sync[1] && q.ch[1].pin_sync[2]) |=> q.ch[1].flag)
        else $error("falling edge not captured");
    a_rise_only: assert property ((ic_mode[1] && q.ch[1].edge_sel == 2'h1
        && !q.ch[1].flag && !q.ch[1].pin_sync[1] && q.ch[1].pin_sync[2]) |=> !q.ch[1].flag)
        else $error("falling edge captured in rise mode");
    a_flag_clear: assert property ((bus.wr && bus.addr == addr_ctl[0]
        && !bus.wdata[BIT_FLAG] && q.ch[0].clear_armed && !cap_event[0]) |=> !q.ch[0].flag)
        else $error("armed clear ignored");
    a_partial_write: assert property ((bus.wr && bus.addr == addr_vh[1] && !ic_mode[1]
        && !debug_mode && !q.ch[1].wr_low_seen) |=> $stable(q.ch[1].value))
        else $error("half written value applied");
    a_debug_write: assert property ((bus.wr && bus.addr == addr_vh[1] && debug_mode
        && !ic_mode[1])
        |=> (q.ch[1].value[15:8] == $past(bus.wdata) && $stable(q.ch[1].wr_buf)))
        else $error("debug write not direct");

    c_capture: cover property (cap_event[0] ##1 q.ch[0].flag);
    c_overflow: cover property ($rose(q.overflow));
    c_flag_clear: cover property ($fell(q.ch[0].flag));
    c_coherent_read: cover property ($rose(q.ch[0].rd_latched) ##[1:20] $fell(q.ch[0].rd_latched));
endmodule

// ---- timer_pkg.sv ----
// constants and carrier types for the 16-bit timer with input capture
// Functional notes
// - capture value byte read latches other byte
// - channel control write releases read latch
// - capture mode ignores channel value writes
// - debug freezes read latch state
// - debug reads return live channel value
// - output modes buffer value writes; control resets
// - debug writes go direct; buffer untouched
// - clock select resets to none
// - clock select none stops, keeps counter
// - external counter clock is synchronised first
// - selected clock feeds 7-bit prescaler
// - 16-bit counter, one step per tick
// - up count zero to modulo, reload
// - up count overflow on modulo to zero
// - center mode counts up then down
// - center overflow on modulo to modulo-1
// - modulo zero or ones: free run
// - counter byte write clears counter
// - capture mode decode from mode, edge and center bits
// - edge select: 01 rise, 10 fall, 11 both
// - selected edge captures counter, sets flag
// - flag set third clock after edge
// - capture keeps working in debug mode
// - debug freezes the counter
// - flag clear is read-then-write-zero
package timer_pkg;
    localparam int NUM_CH = 2;
    // register offsets
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNTER_HIGH = 4'h1;
    localparam logic [3:0] ADDR_COUNTER_LOW = 4'h2;
    localparam logic [3:0] ADDR_MODULO_HIGH = 4'h3;
    localparam logic [3:0] ADDR_MODULO_LOW = 4'h4;
    localparam logic [3:0] ADDR_CH_CONTROL_BASE = 4'h5;
    localparam logic [3:0] ADDR_CH_VALUE_HIGH_BASE = 4'h6;
    localparam logic [3:0] ADDR_CH_VALUE_LOW_BASE = 4'h7;
    localparam logic [3:0] ADDR_CH_STRIDE = 4'h3;
    // field positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_CENTER = 5;
    // clock source encodings
    localparam logic [1:0] CLK_NONE = 2'h0;
    localparam logic [1:0] CLK_SYSTEM = 2'h1;
    localparam logic [1:0] CLK_FIXED = 2'h2;
    localparam logic [1:0] CLK_EXTERNAL = 2'h3;
    // channel mode encodings
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] edge_sel;
        logic irq_en;
        logic flag;
        logic clear_armed;
        logic [15:0] value;
        logic [15:0] rd_buf;
        logic rd_latched;
        logic rd_first_high;
        logic [15:0] wr_buf;
        logic wr_high_seen;
        logic wr_low_seen;
        logic [2:0] pin_sync;
    } channel_t;

    typedef struct packed {
        logic overflow;
        logic overflow_armed;
        logic overflow_irq_en;
        logic center;
        logic [1:0] clock_source_select;
        logic [2:0] presc;
        logic [6:0] pre_cnt;
        logic [15:0] count;
        logic count_down;
        logic [15:0] modulo;
        logic [15:0] mod_buf;
        logic mod_high_seen;
        logic mod_low_seen;
        logic [2:0] ext_sync;
        logic [7:0] rdata;
        channel_t [NUM_CH-1:0] ch;
    } state_t;

    // everything clears at reset: clock source none, modulo zero
    localparam state_t STATE_RESET = '0;
endpackage

// ---- pin_source.sv ----
// far-side model: capture pin source plus external and fixed counter clock sources
`timescale 1ns/10ps
module pin_source
    import timer_pkg::*;
(
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic [NUM_CH-1:0] pin_target,
    input wire logic src_run,
    // pins toward the timer
    output logic [NUM_CH-1:0] channel_pin,
    output logic ext_clk_pin,
    output logic fixed_clk_tick
);
    logic [2:0] div = 3'h0;

    // pins move just after an edge; the bench holds each level five cycles or more
    always_ff @(posedge clk) begin
        channel_pin <= pin_target;
        div <= src_run ? div + 3'h1 : 3'h0;
    end

    // both sources run at clk/8, under the clk/4 ceiling, and rest low when idle
    assign ext_clk_pin = src_run & div[2];
    assign fixed_clk_tick = src_run & (div == 3'h7);
endmodule

// ---- tb.sv ----
// self-checking bench for the 16-bit timer with input capture
`timescale 1ns/10ps
module tb;
    import timer_pkg::*;
    localparam logic [3:0] C1_CTL = ADDR_CH_CONTROL_BASE + ADDR_CH_STRIDE;
    localparam logic [3:0] C1_HI = ADDR_CH_VALUE_HIGH_BASE + ADDR_CH_STRIDE;
    localparam logic [3:0] C1_LO = ADDR_CH_VALUE_LOW_BASE + ADDR_CH_STRIDE;
    logic clk;
    logic reset_n;
    bus_req_t bus;
    logic [7:0] rdata;
    logic debug_mode;
    logic src_run;
    logic [NUM_CH-1:0] pin_target;
    logic [NUM_CH-1:0] channel_pin;
    logic [NUM_CH-1:0] channel_irq;
    logic ext_clk_pin;
    logic fixed_clk_tick;
    logic overflow_irq;
    logic [7:0] got;
    logic [7:0] ctl;
    int mismatches;
    int check_count;

    timer_counter dut_u (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
        .ext_clk_pin(ext_clk_pin), .fixed_clk_tick(fixed_clk_tick),
        .debug_mode(debug_mode), .channel_pin(channel_pin),
        .channel_irq(channel_irq), .overflow_irq(overflow_irq));

    pin_source src_u (.clk(clk), .pin_target(pin_target), .src_run(src_run),
        .channel_pin(channel_pin), .ext_clk_pin(ext_clk_pin),
        .fixed_clk_tick(fixed_clk_tick));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one access spans two cycles; the idle gap keeps every strobe one cycle long
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        bus <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1 got = rdata;
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, got});
    endtask

    task automatic rd_cnt(input logic [15:0] exp);
        rc(ADDR_COUNTER_HIGH, exp[15:8]);
        rc(ADDR_COUNTER_LOW, exp[7:0]);
    endtask

    // start and stop writes sit k cycles apart, so the counter sees exactly k source cycles
    task automatic run(input logic [7:0] c, input int k);
        wr(ADDR_STATUS_CONTROL, c);
        repeat (k - 2) @(posedge clk);
        wr(ADDR_STATUS_CONTROL, c & 8'h67);
    endtask

    task automatic pin_step(input int ch, input logic lvl);
        pin_target[ch] <= lvl;
        repeat (5) @(posedge clk);
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 68000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        bus = '0;
        reset_n = 1'b0;
        debug_mode = 1'b0;
        src_run = 1'b0;
        pin_target = '0;
        mismatches = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rc(ADDR_STATUS_CONTROL, 8'h00);
        rc(4'hf, 8'h00);
        // every prescale code, modulo zero free-runs
        for (int p = 0; p < 8; p++) begin
            wr(ADDR_COUNTER_LOW, 8'h5a);
            rd_cnt(16'h0000);
            run(8'h08 | 8'(p), 4 << p);
            rd_cnt(16'h0004);
        end
        // up counting, modulo 4
        wr(ADDR_MODULO_HIGH, 8'h00);
        wr(ADDR_MODULO_LOW, 8'h04);
        wr(ADDR_COUNTER_HIGH, 8'h00);
        run(8'h48, 4);
        rd_cnt(16'h0004);
        rc(ADDR_STATUS_CONTROL, 8'h40);
        chk("overflow irq", 16'h0, {15'h0, overflow_irq});
        run(8'h48, 2);
        rd_cnt(16'h0001);
        rc(ADDR_STATUS_CONTROL, 8'hc0);
        chk("overflow irq", 16'h1, {15'h0, overflow_irq});
        wr(ADDR_STATUS_CONTROL, 8'h00);
        rc(ADDR_STATUS_CONTROL, 8'h00);
        // center mode
        wr(ADDR_COUNTER_LOW, 8'h00);
        run(8'h28, 4);
        rd_cnt(16'h0004);
        rc(ADDR_STATUS_CONTROL, 8'h20);
        run(8'h28, 2);
        rd_cnt(16'h0002);
        rc(ADDR_STATUS_CONTROL, 8'ha0);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        // all-ones modulo free-runs through the full range
        wr(ADDR_MODULO_HIGH, 8'hff);
        wr(ADDR_MODULO_LOW, 8'hff);
        wr(ADDR_COUNTER_LOW, 8'h00);
        run(8'h08, 65537);
        rd_cnt(16'h0001);
        rc(ADDR_STATUS_CONTROL, 8'h80);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        // fixed tick and external clock, both at clk/8
        src_run <= 1'b1;
        for (int s = 2; s < 4; s++) begin
            wr(ADDR_COUNTER_LOW, 8'h00);
            run(8'(s << 3), 160);
            rd_cnt(16'h0014);
        end
        src_run <= 1'b0;
        // edge selection on channel 1: rise then fall for each code
        for (int e = 1; e < 4; e++) begin
            ctl = 8'h40 | 8'(e << 2);
            wr(C1_CTL, ctl);
            for (int d = 0; d < 2; d++) begin
                pin_step(1, d == 0);
                chk("irq ch1", {15'h0, e[d]}, {15'h0, channel_irq[1]});
                rc(C1_CTL, ctl | {e[d], 7'h00});
                wr(C1_CTL, ctl);
            end
        end
        // a fresh capture, an armed read, then a write of one must keep the flag
        pin_step(1, 1'b1);
        rc(C1_CTL, 8'hcc);
        wr(C1_CTL, 8'hcc);
        rc(C1_CTL, 8'hcc);
        rc(C1_HI, 8'h00);
        rc(C1_LO, 8'h14);
        // capture latency on channel 0
        wr(ADDR_CH_CONTROL_BASE, 8'h44);
        pin_target[0] <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("irq ch0 early", 16'h0, {15'h0, channel_irq[0]});
        @(posedge clk);
        #1 chk("irq ch0", 16'h1, {15'h0, channel_irq[0]});
        @(posedge clk);
        // read coherency: low first, then a new capture behind the latch
        rc(ADDR_CH_VALUE_LOW_BASE, 8'h14);
        run(8'h08, 300);
        pin_step(0, 1'b0);
        pin_step(0, 1'b1);
        wr(ADDR_CH_VALUE_HIGH_BASE, 8'hab);
        rc(ADDR_CH_VALUE_HIGH_BASE, 8'h00);
        rc(ADDR_CH_VALUE_HIGH_BASE, 8'h01);
        rc(ADDR_CH_CONTROL_BASE, 8'hc4);
        wr(ADDR_CH_CONTROL_BASE, 8'h44);
        run(8'h08, 100);
        pin_step(0, 1'b0);
        pin_step(0, 1'b1);
        rc(ADDR_CH_VALUE_LOW_BASE, 8'ha4);
        rc(ADDR_CH_CONTROL_BASE, 8'hc4);
        wr(ADDR_CH_CONTROL_BASE, 8'h44);
        rc(ADDR_CH_VALUE_HIGH_BASE, 8'h01);
        run(8'h08, 100);
        // debug: counter frozen, capture live, reads bypass the latch
        debug_mode <= 1'b1;
        run(8'h08, 20);
        rd_cnt(16'h0208);
        pin_step(0, 1'b0);
        pin_step(0, 1'b1);
        rc(ADDR_CH_VALUE_LOW_BASE, 8'h08);
        rc(ADDR_CH_CONTROL_BASE, 8'hc4);
        debug_mode <= 1'b0;
        rc(ADDR_CH_VALUE_LOW_BASE, 8'ha4);
        // output compare write buffering on channel 1, counter stopped
        wr(C1_CTL, 8'h10);
        wr(C1_HI, 8'h12);
        wr(C1_LO, 8'h34);
        rc(C1_HI, 8'h12);
        rc(C1_LO, 8'h34);
        wr(C1_HI, 8'h77);
        rc(C1_HI, 8'h12);
        wr(C1_CTL, 8'h10);
        wr(C1_LO, 8'h99);
        rc(C1_LO, 8'h34);
        wr(C1_HI, 8'h01);
        rc(C1_LO, 8'h99);
        debug_mode <= 1'b1;
        wr(C1_HI, 8'h56);
        rc(C1_HI, 8'h56);
        debug_mode <= 1'b0;
        // second reset mid-run with the counter running
        wr(ADDR_STATUS_CONTROL, 8'h09);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rc(ADDR_STATUS_CONTROL, 8'h00);
        rd_cnt(16'h0000);
        wrap_up();
    end
endmodule
